// *** inc/bt_pkg.sv ***
// Shared constants, types and helpers for the external bus timing block
package bt_pkg;

  localparam int         BT_CNT_W              = 3;
  localparam logic [2:0] BT_BASE_PLAIN         = 3'h1;
  localparam logic [2:0] BT_BASE_LATCHED       = 3'h2;
  localparam logic [2:0] BT_BASE_WRITE         = 3'h2;
  localparam logic [2:0] BT_LATCH_CLKS_NARROW  = 3'h1;
  localparam logic [2:0] BT_LATCH_CLKS_WIDE    = 3'h2;
  localparam logic [2:0] BT_WR_WIDTH_NARROW    = 3'h1;
  localparam logic [2:0] BT_WR_WIDTH_WIDE      = 3'h2;
  localparam logic [2:0] BT_HOLD_NONE          = 3'h0;
  localparam logic [2:0] BT_HOLD_LONG          = 3'h1;
  localparam logic [2:0] BT_CODE_WAIT_PT       = 3'h2;
  localparam logic [3:0] BT_STEP_BYTE          = 4'h1;
  localparam logic [3:0] BT_STEP_WORD          = 4'h2;
  localparam logic [3:0] BT_ADDR_RST           = 4'h0;

  typedef enum logic [1:0] {BT_CODE_RD, BT_DATA_RD, BT_DATA_WR} bt_kind_t;

  typedef enum logic [2:0] {
    BT_ST_IDLE, BT_ST_LATCH, BT_ST_SETUP, BT_ST_STROBE, BT_ST_HOLD
  } bt_state_t;

  // Both bus timing registers, held as loose fields
  typedef struct packed {
    logic [1:0] plain_code_length_field;
    logic [1:0] latched_code_length_field;
    logic [1:0] plain_read_length_field;
    logic [1:0] latched_read_length_field;
    logic [1:0] plain_write_length_field;
    logic [1:0] latched_write_length_field;
    logic       latch_width_bit;
    logic       write_hold_bit;
    logic       write_width_bit;
  } bt_cfg_t;

  typedef struct packed {
    bt_kind_t   kind;
    logic       latched;
    logic       burst;
    logic       split16;
    logic       bus16;
    logic       wr_lo;
    logic       wr_hi;
    logic [3:0] addr_low;
  } bt_req_t;

  // Phase lengths in whole clocks
  typedef struct packed {
    logic [2:0] total;
    logic [2:0] latch;
    logic [2:0] setup;
    logic [2:0] strobe;
    logic [2:0] hold;
    logic [2:0] wait_pt;
  } bt_len_t;

  function automatic logic [2:0] bt_cycle_len(input logic [1:0] field,
                                              input logic [2:0] base);
    return base + {1'b0, field};
  endfunction

endpackage

// *** verilog/bt_len_calc.sv ***
// Phase length decoder for one bus cycle
`timescale 1ns/1ps
module bt_len_calc (
  // Timing configuration
  input  bt_pkg::bt_cfg_t cfg,
  // Cycle descriptor
  input  bt_pkg::bt_req_t req,
  input  wire logic       second_byte,
  // Phase lengths
  output bt_pkg::bt_len_t len
);

  always_comb begin
    logic       lat;
    logic [3:0] used;
    lat  = req.latched && !second_byte;
    used = 4'h0;
    len  = '0;
    len.latch = !lat ? 3'h0 : cfg.latch_width_bit ? bt_pkg::BT_LATCH_CLKS_WIDE :
                bt_pkg::BT_LATCH_CLKS_NARROW;
    unique case (req.kind)
      bt_pkg::BT_CODE_RD: begin
        len.total = lat ?
          bt_pkg::bt_cycle_len(cfg.latched_code_length_field, bt_pkg::BT_BASE_LATCHED) :
          bt_pkg::bt_cycle_len(cfg.plain_code_length_field, bt_pkg::BT_BASE_PLAIN);
        len.strobe  = len.total - len.latch;
        len.wait_pt = bt_pkg::BT_CODE_WAIT_PT;
      end
      bt_pkg::BT_DATA_RD: begin
        len.total = lat ?
          bt_pkg::bt_cycle_len(cfg.latched_read_length_field, bt_pkg::BT_BASE_LATCHED) :
          bt_pkg::bt_cycle_len(cfg.plain_read_length_field, bt_pkg::BT_BASE_PLAIN);
        len.strobe  = len.total - len.latch;
        len.wait_pt = len.strobe - 3'h1;
      end
      bt_pkg::BT_DATA_WR: begin
        len.total = bt_pkg::bt_cycle_len(lat ? cfg.latched_write_length_field :
                                         cfg.plain_write_length_field,
                                         bt_pkg::BT_BASE_WRITE);
        len.strobe = cfg.write_width_bit ? bt_pkg::BT_WR_WIDTH_WIDE :
                     bt_pkg::BT_WR_WIDTH_NARROW;
        len.hold = cfg.write_hold_bit ? bt_pkg::BT_HOLD_LONG : bt_pkg::BT_HOLD_NONE;
        used = {1'b0, len.strobe} + {1'b0, len.hold} + {1'b0, len.latch};
        // Setup after latch phase; bad settings collapse to zero
        len.setup = ({1'b0, len.total} > used) ? len.total - used[2:0] : 3'h0;
        len.wait_pt = len.strobe;
      end
      default: ;
    endcase
  end

endmodule

// *** verilog/bt_ale_gen.sv ***
// Address latch pulse with half-clock trailing edge
`timescale 1ns/1ps
module bt_ale_gen (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Latch phase from the sequencer
  input  wire logic phase_on,
  input  wire logic phase_last,
  // Pin
  output logic      ale
);

  logic trim_r;

  // Falling edge cuts the last latch clock in half
  always_ff @(negedge clk or posedge rst) begin
    if (rst) begin
      trim_r <= 1'b0;
    end else begin
      trim_r <= phase_on && phase_last;
    end
  end

  assign ale = phase_on && !trim_r;

endmodule

// *** verilog/bt_bus_timing.sv ***
// External bus cycle sequencer: latch, setup, strobe, hold and wait
`timescale 1ns/1ps
module bt_bus_timing (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Bus timing configuration
  input  bt_pkg::bt_cfg_t cfg,
  // Cycle requests
  input  wire logic       req_valid,
  output logic            req_ready,
  input  bt_pkg::bt_req_t req,
  output logic            cycle_done,
  output logic            busy,
  // External wait
  input  wire logic       wait_in,
  // Memory interface pins
  output logic            ale,
  output logic            code_fetch_strobe_n,
  output logic            rd_n,
  output logic            write_strobe_low_byte_n,
  output logic            write_strobe_high_byte_n,
  output logic            data_oe_n,
  output logic [3:0]      addr_low
);

  bt_pkg::bt_len_t   len_cur;
  bt_pkg::bt_len_t   len_new;
  bt_pkg::bt_state_t state_r;
  bt_pkg::bt_state_t state_nxt;
  bt_pkg::bt_req_t   cur_r;
  bt_pkg::bt_req_t   cur_nxt;
  logic [2:0]        idx_r;
  logic [2:0]        idx_nxt;
  logic              second_r;
  logic              second_nxt;
  logic [3:0]        addr_r;
  logic [3:0]        addr_nxt;
  logic              wait_hold;
  logic              phase_end;
  logic              finish;
  logic              split_go;
  logic              burst_ok;
  logic              burst_go;
  logic              cfs_n_r;
  logic              rd_n_r;
  logic              wr_lo_n_r;
  logic              wr_hi_n_r;
  logic              data_oe_n_r;
  logic              lat_on_r;
  logic              lat_last_r;
  logic              done_r;
  logic [2:0]        lat_clks;

  localparam logic [3:0] BT_A0 = 4'h1;

  bt_len_calc u_len_cur (
    .cfg         (cfg),
    .req         (cur_r),
    .second_byte (second_r),
    .len         (len_cur)
  );

  bt_len_calc u_len_new (
    .cfg         (cfg),
    .req         (req),
    .second_byte (1'b0),
    .len         (len_new)
  );

  bt_ale_gen u_ale (
    .clk        (clk),
    .rst        (rst),
    .phase_on   (lat_on_r),
    .phase_last (lat_last_r),
    .ale        (ale)
  );

  assign lat_clks = cfg.latch_width_bit ? bt_pkg::BT_LATCH_CLKS_WIDE :
                    bt_pkg::BT_LATCH_CLKS_NARROW;

  // Stretch holds the strobe index while wait is high at the sample point
  assign wait_hold = (state_r == bt_pkg::BT_ST_STROBE) && wait_in &&
                     (len_cur.wait_pt != 3'h0) &&
                     (idx_r == len_cur.wait_pt - 3'h1);

  always_comb begin
    unique case (state_r)
      bt_pkg::BT_ST_LATCH:  phase_end = idx_r == len_cur.latch - 3'h1;
      bt_pkg::BT_ST_SETUP:  phase_end = idx_r == len_cur.setup - 3'h1;
      bt_pkg::BT_ST_STROBE: phase_end = (idx_r == len_cur.strobe - 3'h1) && !wait_hold;
      bt_pkg::BT_ST_HOLD:   phase_end = idx_r == len_cur.hold - 3'h1;
      default:              phase_end = 1'b0;
    endcase
  end

  assign finish = phase_end && ((state_r == bt_pkg::BT_ST_HOLD) ||
                  ((state_r == bt_pkg::BT_ST_STROBE) && (len_cur.hold == 3'h0)));
  assign split_go = finish && (cur_r.kind == bt_pkg::BT_DATA_RD) &&
                    cur_r.split16 && !second_r;
  assign burst_ok = finish && (cur_r.kind == bt_pkg::BT_CODE_RD) &&
                    (req.kind == bt_pkg::BT_CODE_RD) && req.burst;
  assign burst_go = burst_ok && req_valid;
  assign req_ready = (state_r == bt_pkg::BT_ST_IDLE) || burst_ok;
  assign busy      = state_r != bt_pkg::BT_ST_IDLE;

  always_comb begin
    state_nxt  = state_r;
    idx_nxt    = idx_r + 3'h1;
    cur_nxt    = cur_r;
    second_nxt = second_r;
    addr_nxt   = addr_r;
    unique case (state_r)
      bt_pkg::BT_ST_IDLE: begin
        idx_nxt = 3'h0;
        if (req_valid) begin
          cur_nxt    = req;
          second_nxt = 1'b0;
          addr_nxt   = req.addr_low;
          if (req.latched) begin
            state_nxt = bt_pkg::BT_ST_LATCH;
          end else if (req.kind == bt_pkg::BT_DATA_WR && len_new.setup != 3'h0) begin
            state_nxt = bt_pkg::BT_ST_SETUP;
          end else begin
            state_nxt = bt_pkg::BT_ST_STROBE;
          end
        end
      end
      bt_pkg::BT_ST_LATCH: begin
        if (phase_end) begin
          idx_nxt = 3'h0;
          // Latched write waits out the gap before its strobe
          state_nxt = (cur_r.kind == bt_pkg::BT_DATA_WR && len_cur.setup != 3'h0) ?
                      bt_pkg::BT_ST_SETUP : bt_pkg::BT_ST_STROBE;
        end
      end
      bt_pkg::BT_ST_SETUP: begin
        if (phase_end) begin
          idx_nxt   = 3'h0;
          state_nxt = bt_pkg::BT_ST_STROBE;
        end
      end
      bt_pkg::BT_ST_STROBE: begin
        if (wait_hold) begin
          idx_nxt = idx_r;
        end else if (phase_end) begin
          idx_nxt   = 3'h0;
          state_nxt = (len_cur.hold != 3'h0) ? bt_pkg::BT_ST_HOLD : bt_pkg::BT_ST_IDLE;
        end
      end
      bt_pkg::BT_ST_HOLD: begin
        if (phase_end) begin
          idx_nxt   = 3'h0;
          state_nxt = bt_pkg::BT_ST_IDLE;
        end
      end
      default: begin
        idx_nxt   = 3'h0;
        state_nxt = bt_pkg::BT_ST_IDLE;
      end
    endcase
    if (split_go) begin
      // Second byte: plain timing, A0 rises, read strobe stays low
      state_nxt  = bt_pkg::BT_ST_STROBE;
      second_nxt = 1'b1;
      addr_nxt   = addr_r | BT_A0;
    end else if (burst_go) begin
      state_nxt       = bt_pkg::BT_ST_STROBE;
      cur_nxt         = req;
      cur_nxt.latched = 1'b0;
      addr_nxt        = addr_r + (req.bus16 ? bt_pkg::BT_STEP_WORD :
                                  bt_pkg::BT_STEP_BYTE);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r  <= bt_pkg::BT_ST_IDLE;
      idx_r    <= 3'h0;
      second_r <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      idx_r    <= idx_nxt;
      second_r <= second_nxt;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cur_r  <= '0;
      addr_r <= bt_pkg::BT_ADDR_RST;
    end else begin
      cur_r  <= cur_nxt;
      addr_r <= addr_nxt;
    end
  end

  // Pin strobes follow the next state so they leave flops cleanly
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfs_n_r     <= 1'b1;
      rd_n_r      <= 1'b1;
      wr_lo_n_r   <= 1'b1;
      wr_hi_n_r   <= 1'b1;
      data_oe_n_r <= 1'b1;
    end else begin
      cfs_n_r <= !(state_nxt == bt_pkg::BT_ST_STROBE &&
                   cur_nxt.kind == bt_pkg::BT_CODE_RD);
      rd_n_r  <= !(state_nxt == bt_pkg::BT_ST_STROBE &&
                   cur_nxt.kind == bt_pkg::BT_DATA_RD);
      wr_lo_n_r <= !(state_nxt == bt_pkg::BT_ST_STROBE &&
                     cur_nxt.kind == bt_pkg::BT_DATA_WR && cur_nxt.wr_lo);
      wr_hi_n_r <= !(state_nxt == bt_pkg::BT_ST_STROBE &&
                     cur_nxt.kind == bt_pkg::BT_DATA_WR && cur_nxt.wr_hi);
      data_oe_n_r <= !(cur_nxt.kind == bt_pkg::BT_DATA_WR &&
                       (state_nxt == bt_pkg::BT_ST_SETUP ||
                        state_nxt == bt_pkg::BT_ST_STROBE ||
                        state_nxt == bt_pkg::BT_ST_HOLD));
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lat_on_r   <= 1'b0;
      lat_last_r <= 1'b0;
      done_r     <= 1'b0;
    end else begin
      lat_on_r   <= state_nxt == bt_pkg::BT_ST_LATCH;
      lat_last_r <= (state_nxt == bt_pkg::BT_ST_LATCH) &&
                    (idx_nxt == lat_clks - 3'h1);
      done_r     <= finish;
    end
  end

  assign code_fetch_strobe_n      = cfs_n_r;
  assign rd_n                     = rd_n_r;
  assign write_strobe_low_byte_n  = wr_lo_n_r;
  assign write_strobe_high_byte_n = wr_hi_n_r;
  assign data_oe_n                = data_oe_n_r;
  assign addr_low                 = addr_r;
  assign cycle_done               = done_r;

  // Checking helpers: strobe and cycle lengths, stretch and chain marks
  logic [2:0] low_cnt_r;
  logic [2:0] cyc_cnt_r;
  logic       waited_r;
  logic       multi_r;
  logic       any_strobe_low;

  assign any_strobe_low = !(cfs_n_r && rd_n_r && wr_lo_n_r && wr_hi_n_r);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_cnt_r <= 3'h0;
      cyc_cnt_r <= 3'h0;
      waited_r  <= 1'b0;
      multi_r   <= 1'b0;
    end else begin
      low_cnt_r <= any_strobe_low ? low_cnt_r + 3'h1 : 3'h0;
      cyc_cnt_r <= busy ? cyc_cnt_r + 3'h1 : 3'h0;
      if (!busy && req_valid) begin
        waited_r <= 1'b0;
        multi_r  <= 1'b0;
      end else begin
        waited_r <= waited_r || wait_hold;
        multi_r  <= multi_r || split_go || burst_go;
      end
    end
  end

  ale_narrow_a: assert property (@(posedge clk) disable iff (rst)
    $rose(lat_on_r) && !cfg.latch_width_bit |=> !lat_on_r)
    else $error("narrow latch phase not one clock");

  ale_wide_a: assert property (@(posedge clk) disable iff (rst)
    $rose(lat_on_r) && cfg.latch_width_bit |=> lat_on_r ##1 !lat_on_r)
    else $error("wide latch phase not two clocks");

  code_plain_len_a: assert property (@(posedge clk) disable iff (rst)
    $rose(cfs_n_r) && !waited_r && !multi_r && !cur_r.latched |->
      low_cnt_r == bt_pkg::bt_cycle_len(cfg.plain_code_length_field,
                                        bt_pkg::BT_BASE_PLAIN))
    else $error("plain code read length wrong");

  code_latch_total_a: assert property (@(posedge clk) disable iff (rst)
    $fell(busy) && cur_r.kind == bt_pkg::BT_CODE_RD && cur_r.latched &&
    !waited_r && !multi_r |->
      cyc_cnt_r == bt_pkg::bt_cycle_len(cfg.latched_code_length_field,
                                        bt_pkg::BT_BASE_LATCHED))
    else $error("latched code cycle length wrong");

  code_latch_strobe_a: assert property (@(posedge clk) disable iff (rst)
    $rose(cfs_n_r) && !waited_r && !multi_r && cur_r.latched |->
      low_cnt_r == bt_pkg::bt_cycle_len(cfg.latched_code_length_field,
                                        bt_pkg::BT_BASE_LATCHED) - lat_clks)
    else $error("latched code strobe width wrong");

  read_plain_len_a: assert property (@(posedge clk) disable iff (rst)
    $rose(rd_n_r) && !waited_r && !multi_r && !cur_r.latched |->
      low_cnt_r == bt_pkg::bt_cycle_len(cfg.plain_read_length_field,
                                        bt_pkg::BT_BASE_PLAIN))
    else $error("plain read strobe length wrong");

  read_latch_len_a: assert property (@(posedge clk) disable iff (rst)
    $fell(busy) && cur_r.kind == bt_pkg::BT_DATA_RD && cur_r.latched &&
    !waited_r && !multi_r |->
      cyc_cnt_r == bt_pkg::bt_cycle_len(cfg.latched_read_length_field,
                                        bt_pkg::BT_BASE_LATCHED))
    else $error("latched read cycle length wrong");

  split_rd_low_a: assert property (@(posedge clk) disable iff (rst)
    $rose(second_r) |-> !rd_n_r && !$past(rd_n_r))
    else $error("read strobe toggled between split bytes");

  wr_width_a: assert property (@(posedge clk) disable iff (rst)
    $rose(wr_lo_n_r && wr_hi_n_r) && !waited_r |->
      low_cnt_r == (cfg.write_width_bit ? 3'h2 : 3'h1))
    else $error("write strobe width wrong");

  wr_hold_a: assert property (@(posedge clk) disable iff (rst)
    $rose(wr_lo_n_r && wr_hi_n_r) |->
      if (cfg.write_hold_bit) (!data_oe_n_r ##1 data_oe_n_r) else data_oe_n_r)
    else $error("write data hold wrong");

  wr_total_a: assert property (@(posedge clk) disable iff (rst)
    $fell(busy) && cur_r.kind == bt_pkg::BT_DATA_WR && !waited_r &&
    ({1'b0, len_cur.total} >= {1'b0, len_cur.strobe} + {1'b0, len_cur.hold} +
     {1'b0, len_cur.latch}) |->
      cyc_cnt_r == bt_pkg::bt_cycle_len(cur_r.latched ? cfg.latched_write_length_field :
                                        cfg.plain_write_length_field,
                                        bt_pkg::BT_BASE_WRITE))
    else $error("write cycle length wrong");

  burst_step_a: assert property (@(posedge clk) disable iff (rst)
    burst_go |=> !cfs_n_r && !$past(cfs_n_r) &&
      addr_r == $past(addr_r) + ($past(req.bus16) ? 4'h2 : 4'h1))
    else $error("burst fetch strobe or address step wrong");

  wait_stretch_a: assert property (@(posedge clk) disable iff (rst)
    wait_hold |=> state_r == bt_pkg::BT_ST_STROBE && idx_r == $past(idx_r))
    else $error("wait did not stretch strobe");

endmodule

// *** sim/bt_mem_model.sv ***
// External memory wait model for the bus timing block
`timescale 1ns/1ps
module bt_mem_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Bus pins seen by the memory
  input  wire logic       strobe_n,
  input  wire logic       a0,
  // Wait setup: strobe clock index and clocks of stretch
  input  wire logic [2:0] wait_at,
  input  wire logic [2:0] stretch,
  // Wait request, pulled low when idle
  output logic            wait_in
);
  logic [3:0] n_r;
  logic       a0_r;

  // Strobe clock index, restarted by a rising low address bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      n_r  <= 4'h0;
      a0_r <= 1'b0;
    end else begin
      a0_r <= a0;
      if (strobe_n || (a0 && !a0_r)) begin
        n_r <= 4'h0;
      end else begin
        n_r <= n_r + 4'h1;
      end
    end
  end

  assign wait_in = !strobe_n && (n_r + 4'h1 >= {1'b0, wait_at})
                   && (n_r + 4'h1 < {1'b0, wait_at} + {1'b0, stretch});
endmodule

// *** sim/bt_bus_timing_tb.sv ***
// Self-checking bench for the external bus timing block
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin n_errors++; \
  $display("[ERR] %s exp %0h got %0h", n, e, s); end end
module bt_bus_timing_tb;
  localparam int B = 0, C = 1, R = 2, L = 3, H = 4, O = 5, P = 6, Q = 7, CR = 8, RR = 9, D = 10;
  logic            clk, rst, req_valid, wait_in, req_ready, cycle_done, busy, ale;
  logic            cs_n, rd_n, wl_n, wh_n, oe_n, seen;
  logic [3:0]      addr_low;
  logic [2:0]      wait_at, stretch;
  bt_pkg::bt_cfg_t cfg;
  bt_pkg::bt_req_t req;
  int              n_errors, checks_done;
  int              c [11];
  realtime         t0, aw;

  bt_bus_timing dut (.clk(clk), .rst(rst), .cfg(cfg), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .cycle_done(cycle_done), .busy(busy),
    .wait_in(wait_in), .ale(ale), .code_fetch_strobe_n(cs_n), .rd_n(rd_n),
    .write_strobe_low_byte_n(wl_n), .write_strobe_high_byte_n(wh_n),
    .data_oe_n(oe_n), .addr_low(addr_low));
  bt_mem_model mem (.clk(clk), .rst(rst), .strobe_n(cs_n & rd_n & wl_n & wh_n),
    .a0(addr_low[0]), .wait_at(wait_at), .stretch(stretch), .wait_in(wait_in));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Clock counts of each pin state per transfer
  always @(posedge clk) begin
    c[B] += busy;
    c[C] += !cs_n;
    c[R] += !rd_n;
    c[L] += !wl_n;
    c[H] += !wh_n;
    c[O] += !oe_n;
    c[D] += cycle_done;
    if (!(wl_n && wh_n)) seen = 1'b1;
    else if (busy && !seen) c[P]++;
    else if (seen && !oe_n) c[Q]++;
  end
  always @(posedge cs_n) c[CR]++;
  always @(posedge rd_n) c[RR]++;
  always @(posedge ale) t0 = $realtime;
  always @(negedge ale) aw = $realtime - t0;

  task complete_run;
    $display("Checks %0d, errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Issue one request, accept n times, wait for idle
  task automatic run(input bt_pkg::bt_kind_t k, input logic [4:0] f, input int n);
    int i;
    @(negedge clk);
    c = '{default: 0};
    seen = 1'b0;
    aw = 0;
    @(posedge clk);
    req <= '{kind: k, latched: f[4], burst: f[3], split16: f[2], bus16: f[1],
             wr_lo: !f[0], wr_hi: f[0], addr_low: 4'h4};
    req_valid <= 1'b1;
    for (i = 0; i < n;) begin
      @(posedge clk);
      if (req_ready) i++;
    end
    req_valid <= 1'b0;
    repeat (2) @(posedge clk);
    for (i = 0; i < 60 && busy; i++) @(posedge clk);
    repeat (2) @(posedge clk);
  endtask

  task automatic rdc(input bt_pkg::bt_kind_t k, input int f, a, l);
    run(k, {l[0], 4'h0}, 1);
    `CHK("read_len", f + 1 + l, c[B])
    `CHK("read_done", 1, c[D])
    `CHK("read_strobe", f + 1 - l * a, c[k == bt_pkg::BT_CODE_RD ? C : R])
    if (l) `CHK("ale_width", 5 + 10 * a, int'(aw * 2))
  endtask

  task automatic wr(input int f, a, w, h, l);
    run(bt_pkg::BT_DATA_WR, {l[0], 3'h0, f[0]}, 1);
    `CHK("wr_len", f + 2, c[B])
    `CHK("wr_strobe", w + 1, c[f[0] ? H : L])
    `CHK("wr_other", 0, c[f[0] ? L : H])
    `CHK("wr_setup", f + 1 - w - h, c[P])
    `CHK("wr_hold", h, c[Q])
    `CHK("wr_data", f + 2 - l * (a + 1), c[O])
  endtask

  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    cfg = '0;
    req = '0;
    wait_at = 3'h0;
    stretch = 3'h0;
    n_errors = 0;
    checks_done = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK("idle_pins", 12'h7e0, {busy, req_ready, cs_n, rd_n, wl_n, wh_n, oe_n, ale, addr_low})
    // Skip settings with an empty strobe or a negative setup; zero setup stays in to see its effect
    for (int f = 0; f < 4; f++)
      for (int a = 0; a < 2; a++)
        for (int w = 0; w < 2; w++)
          for (int h = 0; h < 2; h++) begin
            cfg <= {{6{f[1:0]}}, a[0], h[0], w[0]};
            for (int l = 0; l < 2; l++) begin
              if (l == 0 || f >= a) rdc(bt_pkg::BT_CODE_RD, f, a, l);
              if (l == 0 || f >= a) rdc(bt_pkg::BT_DATA_RD, f, a, l);
              if (f + 1 >= w + h + l * (a + 1)) wr(f, a, w, h, l);
            end
          end
    cfg <= {{6{2'h1}}, 3'h1};
    for (int b = 0; b < 2; b++) begin
      run(bt_pkg::BT_CODE_RD, {2'h1, 1'b0, b[0], 1'b0}, 3);
      `CHK("burst_strobe", 6, c[C])
      `CHK("burst_done", 3, c[D])
      `CHK("burst_edges", 1, c[CR])
      `CHK("burst_addr", 4'h6 + 4'(2 * b), addr_low)
    end
    run(bt_pkg::BT_DATA_RD, 5'h14, 1);
    `CHK("split_len", 5, c[B])
    `CHK("split_strobe", 4, c[R])
    `CHK("split_edges", 1, c[RR])
    `CHK("split_done", 2, c[D])
    `CHK("split_a0", 1'b1, addr_low[0])
    stretch <= 3'h2;
    wait_at <= 3'h2;
    run(bt_pkg::BT_CODE_RD, 5'h0, 1);
    `CHK("code_wait", 4, c[B])
    cfg <= {{6{2'h2}}, 3'h3};
    run(bt_pkg::BT_DATA_RD, 5'h0, 1);
    `CHK("read_wait", 5, c[B])
    run(bt_pkg::BT_DATA_WR, 5'h0, 1);
    `CHK("write_wait", 6, c[B])
    cfg <= {{6{2'h0}}, 3'h2};
    wait_at <= 3'h0;
    run(bt_pkg::BT_DATA_RD, 5'h0, 1);
    `CHK("short_read", 1, c[B])
    complete_run();
  end

  initial begin
    #150000;
    n_errors++;
    complete_run();
  end
endmodule
